// File: hdl/ctl_cfg.svh
// Purpose: Offsets, field positions, reset values and timing counts of the switch controller.
// Assumes: 16-bit serial words, two channels, a 50 MHz pclk.
// Notes: Included by both ends; the package does not include it.
`ifndef CTL_CFG_SVH
`define CTL_CFG_SVH
`define CLK_HZ 50000000
`define WD_TIMEOUT_MS 310
`define IN_IDLE_MS 250
`define WD_CYC (`CLK_HZ / 1000 * `WD_TIMEOUT_MS)
`define IN_CYC (`CLK_HZ / 1000 * `IN_IDLE_MS)
`define RETRY_BASE_CYC 50000
`define INT_DIV_CYC 16
`define SPI_DIV_CYC 8
`define CNT_W 24
// Serial word layout.
`define W_WD 15
`define W_ADDR_HI 14
`define W_ADDR_LO 12
`define W_RD 11
`define W_RSEL_HI 9
`define W_RSEL_LO 8
`define WORD_BITS 5'h10
// Register addresses inside the device.
`define A_DUTY0 3'h0
`define A_DUTY1 3'h1
`define A_CFG0 3'h2
`define A_CFG1 3'h3
`define A_OCR0 3'h4
`define A_OCR1 3'h5
`define A_GCR 3'h6
`define A_RETRY 3'h7
// Read selections.
`define R_STAT 2'h0
`define R_F0 2'h1
`define R_F1 2'h2
`define R_GCR 2'h3
// Field positions.
`define DUTY_ON 8
`define CFG_DIRDIS 3
`define OCR_PRESC 1
`define OCR_CLKINT 0
`define GCR_PWM0 7
`define GCR_PAR 6
`define GCR_CLKF_EN 5
`define GCR_WDDIS 4
`define GCR_OV_EN 3
`define GCR_OLOFF_EN 2
`define GCR_OLON_EN 1
`define GCR_OS_EN 0
`define RT_EN 4
// Reset values.
`define GCR_RST 9'h028
`define OCR_RST 2'h1
`define RETRY_RST 8'h1F
`define DUTY_FULL 8'hFF
`define DLY_SHIFT 5'h00
// Synchroniser slots in the device.
`define SY_SCLK 0
`define SY_CS 1
`define SY_MOSI 2
`define SY_RST 3
`define SY_IN0 4
`define SY_EXT 6
// Host APB offsets.
`define H_CMD 8'h00
`define H_RX 8'h04
`define H_PINS 8'h08
`define H_STAT 8'h0C
`define HOST_EDGES 6'h20
`endif

// File: hdl/ctl_link_if.sv
// Purpose: Pins between the host controller and the switch device.
// Assumes: Both ends run on the same pclk; the device synchronises anyway.
// Notes: All signals are one-way; no two-way pins.
`timescale 1ns/1ns
`default_nettype none
interface ctl_link_if;
  logic sclk;
  logic cs_n;
  logic mosi;
  logic miso;
  logic reset_pin_n;
  logic [1:0] dir_in;
  logic failsafe_out_n;
  logic fault_status_n;
  modport dev (input sclk, cs_n, mosi, reset_pin_n, dir_in, output miso, failsafe_out_n, fault_status_n);
  modport host (output sclk, cs_n, mosi, reset_pin_n, dir_in, input miso, failsafe_out_n, fault_status_n);
endinterface
`default_nettype wire

// File: hdl/ctl_pkg.sv
// Purpose: Types shared by both ends of the switch controller link.
// Assumes: Widths match ctl_cfg.svh; the package uses none of its macros.
// Notes: Each end, switch_ctl and switch_host, keeps all its state in one packed struct.
package ctl_pkg;
  typedef enum logic [2:0] {M_NORMAL = 3'h1, M_FAILSAFE = 3'h2, M_FS_EXIT = 3'h4} mode_t;
  typedef enum logic [2:0] {H_IDLE = 3'h1, H_SHIFT = 3'h2, H_GAP = 3'h4} host_phase_t;
  typedef struct packed {
    mode_t mode;
    logic [6:0] sy1;
    logic [6:0] sy2;
    logic [6:0] prv;
    logic [15:0] rx;
    logic [4:0] bitcnt;
    logic [15:0] tx;
    logic [15:0] reply;
    logic miso;
    logic last_wd;
    logic wd_run;
    logic [23:0] wd_cnt;
    logic [1:0][8:0] duty;
    logic [1:0][3:0] cfg;
    logic [1:0][1:0] ocr;
    logic [8:0] global_config_register;
    logic [7:0] retry;
    logic [1:0][5:0] fault;
    logic st_uv;
    logic st_ov;
    logic st_clk;
    logic por;
    logic [1:0] in_on;
    logic [1:0][23:0] in_cnt;
    logic [1:0] off;
    logic [1:0] latched;
    logic [1:0] blocked;
    logic [1:0][3:0] rcnt;
    logic [1:0][23:0] rtim;
    logic [1:0] fc_prev;
    logic [1:0] fc_hi;
    logic [7:0] div_cnt;
    logic ext_half;
    logic [1:0][7:0] dly;
    logic [1:0][7:0] pcnt;
    logic [1:0] running;
    logic [1:0] hson;
    logic fmode;
    logic fs_n;
    logic fsb_n;
  } dev_state_t;
  typedef struct packed {
    host_phase_t phase;
    logic [2:0] sy1;
    logic [2:0] sy2;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    logic [15:0] tx;
    logic [15:0] rx;
    logic [15:0] rxw;
    logic [7:0] div;
    logic [5:0] edges;
    logic sclk;
    logic cs_n;
    logic mosi;
    logic [2:0] pins;
  } host_state_t;
endpackage

// File: hdl/switch_ctl.sv
// Purpose: Mode, fault and PWM control of a two-channel smart output switch.
// Assumes: Fault causes arrive as levels on pclk; link pins are asynchronous.
// Notes: Serial word D15 watchdog bit, D14..D12 address, D11 read, D8..D0 data.
//
// The register offsets and the APB register port were decided locally.
`timescale 1ns/1ns
`default_nettype none
`include "ctl_cfg.svh"
// Operation
// - Watchdog starts on reset pin rising edge.
// - No watchdog bit toggle in timeout enters failsafe.
// - Exit failsafe: D15 word, then second word.
// - Normal entry resets regs, keeps latched fault bits.
// - Enabled faults enter fault mode; defaults apply.
// - Status pin real time; sticky bits until read.
// - Faults switch channel off; supply faults both.
// - Read clears bit only if gone, unlatched.
// - Failsafe: registers reset, inputs control channels.
// - Fault leaving in failsafe keeps latches, releases pin.
// - Latchable fault: off, pin low, bit blocked.
// - Retry turns channel on after programmed interval.
// - Persisting fault after retries latches channel.
// - Delatch by 1-0-1 control or retry reset.
// - Control signal is inputs-activity or enable bit.
// - Host holds input low or toggles enable.
// - Delatch during retry turns channel on.
// - Power-on and failsafe entry delatch channels.
// - Per-channel PWM, internal or external clock.
// - Duty code n gives (n+1)/256 on-time.
// - Switch-on delay is code times 32 periods.
// - Host sets PWM enable after duty, delay.
// - Input idle past timeout drops activity flag.
// - Channel target combines input, enable and PWM.
module switch_ctl import ctl_pkg::*; #(
  parameter int WD_CYC = `WD_CYC,
  parameter int IN_CYC = `IN_CYC,
  parameter int RETRY_BASE = `RETRY_BASE_CYC,
  parameter int INT_DIV = `INT_DIV_CYC
) (
  input wire logic pclk, // System clock.
  input wire logic presetn, // Asynchronous reset, active low.
  ctl_link_if.dev link, // Serial link and status pins.
  input wire logic vdd_ok, // Logic supply present.
  input wire logic ext_clk_pin, // External PWM clock pin.
  input wire logic [1:0] overcurrent_fault, // Overcurrent per channel.
  input wire logic [1:0] short_circuit_fault, // Severe short per channel.
  input wire logic [1:0] overtemp_fault, // Overtemperature per channel.
  input wire logic [1:0] short_to_supply, // Output shorted to supply.
  input wire logic [1:0] open_load_on, // Open load in on state.
  input wire logic [1:0] open_load_off, // Open load in off state.
  input wire logic undervoltage_fault, // Supply undervoltage.
  input wire logic overvoltage, // Supply overvoltage.
  input wire logic ext_clock_fail, // External clock out of range.
  output logic [1:0] hson, // Channel on commands.
  output logic fault_mode // Device is in fault mode.
);
  localparam logic [23:0] WD_LIM = 24'(WD_CYC);
  localparam logic [23:0] IN_LIM = 24'(IN_CYC);
  localparam logic [7:0] DIV_LIM = 8'(INT_DIV - 1);
  dev_state_t s;
  dev_state_t n;

  // Outputs come straight from the state flops.
  assign link.miso = s.miso;
  assign link.failsafe_out_n = s.fs_n;
  assign link.fault_status_n = s.fsb_n;
  assign hson = s.hson;
  assign fault_mode = s.fmode;

  // Next-state logic for the whole device.
  always_comb begin
    logic [6:0] sy;
    logic sclk_rise, sclk_fall, cs_fall, cs_rise, word_done, rst_rise, wd_flip, wd_to;
    logic [15:0] w;
    logic to_fs, to_norm, rd_ok, wr_ok, retry_rst, ovf, clkf, int_tick, ext_rise;
    logic [1:0][5:0] c;
    logic [1:0][5:0] clr;
    logic [1:0] lf, fc, dl, tick, pen, pout, tgt;
    logic [2:0] st_clr;
    logic [23:0] rt_lim;
    n = s;
    sy = s.sy2;
    w = s.rx;
    c = '0;
    clr = '0;
    lf = '0;
    fc = '0;
    dl = '0;
    tick = '0;
    pen = '0;
    pout = '0;
    tgt = '0;
    st_clr = '0;
    to_fs = 1'b0;
    to_norm = 1'b0;
    retry_rst = 1'b0;
    word_done = 1'b0;
    rst_rise = 1'b0;
    wd_flip = 1'b0;
    wd_to = 1'b0;
    rd_ok = 1'b0;
    wr_ok = 1'b0;
    int_tick = 1'b0;
    rt_lim = '0;
    n.sy1 = {ext_clk_pin, link.dir_in, link.reset_pin_n, link.mosi, link.cs_n, link.sclk};
    n.sy2 = s.sy1;
    n.prv = s.sy2;
    sclk_rise = sy[`SY_SCLK] & ~s.prv[`SY_SCLK];
    sclk_fall = ~sy[`SY_SCLK] & s.prv[`SY_SCLK];
    cs_fall = ~sy[`SY_CS] & s.prv[`SY_CS];
    cs_rise = sy[`SY_CS] & ~s.prv[`SY_CS];
    ext_rise = sy[`SY_EXT] & ~s.prv[`SY_EXT];
    ovf = overvoltage & s.global_config_register[`GCR_OV_EN];
    clkf = ext_clock_fail & s.global_config_register[`GCR_CLKF_EN];

    // Serial shifter: sample on rising sclk, shift reply out on falling sclk.
    if (cs_fall) begin
      n.bitcnt = '0;
      n.tx = s.reply;
      n.miso = s.reply[15];
    end else if (!sy[`SY_CS] && sclk_rise) begin
      n.rx = {s.rx[14:0], sy[`SY_MOSI]};
      n.bitcnt = s.bitcnt + 5'h01;
    end else if (!sy[`SY_CS] && sclk_fall) begin
      n.tx = {s.tx[14:0], 1'b0};
      n.miso = s.tx[14];
    end
    word_done = cs_rise & (s.bitcnt == `WORD_BITS);

    // Watchdog runs from a reset-pin rise and restarts on each toggle of D15.
    rst_rise = sy[`SY_RST] & ~s.prv[`SY_RST];
    if (!sy[`SY_RST]) begin
      n.wd_run = 1'b0;
    end else if (rst_rise && vdd_ok) begin
      n.wd_run = 1'b1;
    end
    wd_flip = word_done & (w[`W_WD] != s.last_wd);
    if (word_done) begin
      n.last_wd = w[`W_WD];
    end
    if (wd_flip || rst_rise || (!s.wd_run && s.mode == M_NORMAL)) begin
      n.wd_cnt = '0;
    end else if (s.wd_cnt != WD_LIM) begin
      n.wd_cnt = s.wd_cnt + 24'h000001;
    end
    wd_to = s.wd_run & (s.wd_cnt == WD_LIM) & ~s.global_config_register[`GCR_WDDIS];

    // Operating mode: normal, failsafe, and the wait for the second word.
    case (s.mode)
      M_NORMAL: begin
        if (wd_to) begin
          to_fs = 1'b1;
        end
      end
      M_FAILSAFE: begin
        if (word_done && w[`W_WD]) begin
          n.mode = M_FS_EXIT;
          n.wd_cnt = '0;
        end
      end
      M_FS_EXIT: begin
        if (word_done) begin
          to_norm = 1'b1;
        end else if (s.wd_cnt == WD_LIM) begin
          n.mode = M_FAILSAFE;
        end
      end
      default: begin
        to_fs = 1'b1;
      end
    endcase
    if (to_fs) begin
      n.mode = M_FAILSAFE;
    end
    if (to_norm) begin
      n.mode = M_NORMAL;
    end

    // Register access only in normal mode; reads clear what has gone away.
    rd_ok = word_done & w[`W_RD] & (s.mode == M_NORMAL) & ~to_fs;
    wr_ok = word_done & ~w[`W_RD] & (s.mode == M_NORMAL) & ~to_fs;
    if (rd_ok) begin
      case (w[`W_RSEL_HI:`W_RSEL_LO])
        `R_STAT: begin
          n.reply = {6'h00, s.fsb_n, s.latched, s.fmode, ~s.fs_n, 1'b1, s.st_clk, s.st_ov, s.st_uv, s.por};
          st_clr = {~clkf, ~ovf, ~undervoltage_fault};
          n.por = 1'b0;
        end
        `R_F0: begin
          n.reply = {10'h000, s.fault[0]};
          clr[0] = 6'h3F;
        end
        `R_F1: begin
          n.reply = {10'h000, s.fault[1]};
          clr[1] = 6'h3F;
        end
        default: begin
          n.reply = {7'h00, s.global_config_register};
        end
      endcase
    end
    if (wr_ok) begin
      case (w[`W_ADDR_HI:`W_ADDR_LO])
        `A_DUTY0: n.duty[0] = w[8:0];
        `A_DUTY1: n.duty[1] = w[8:0];
        `A_CFG0: n.cfg[0] = w[3:0];
        `A_CFG1: n.cfg[1] = w[3:0];
        `A_OCR0: n.ocr[0] = w[7:6];
        `A_OCR1: n.ocr[1] = w[7:6];
        `A_GCR: n.global_config_register = w[8:0];
        default: begin
          n.retry = w[7:0];
          retry_rst = w[`RT_EN];
        end
      endcase
    end

    // Mode changes reset the register contents but keep the parallel bit.
    if (to_fs || to_norm) begin
      n.duty = '0;
      n.cfg = '0;
      n.ocr = {2{`OCR_RST}};
      n.global_config_register = `GCR_RST | (s.global_config_register & (9'h001 << `GCR_PAR));
      n.retry = `RETRY_RST;
      n.st_uv = 1'b0;
      n.st_ov = 1'b0;
      n.st_clk = 1'b0;
    end

    // Internal PWM clock from a divider; external one optionally halved.
    int_tick = (s.div_cnt == DIV_LIM);
    n.div_cnt = int_tick ? 8'h00 : s.div_cnt + 8'h01;
    if (ext_rise) begin
      n.ext_half = ~s.ext_half;
    end

    // Per-channel fault handling, retry, delatch and PWM.
    rt_lim = 24'(RETRY_BASE * (int'(s.retry[7:5]) + 1));
    for (int i = 0; i < 2; i++) begin
      c[i] = {open_load_off[i] & s.global_config_register[`GCR_OLOFF_EN], open_load_on[i] & s.global_config_register[`GCR_OLON_EN],
              short_to_supply[i] & s.global_config_register[`GCR_OS_EN], overtemp_fault[i], short_circuit_fault[i],
              overcurrent_fault[i]};
      lf[i] = overcurrent_fault[i] | short_circuit_fault[i] | overtemp_fault[i] | undervoltage_fault;
      // Input activity flag drops after an idle input stays low too long.
      if (sy[`SY_IN0 + i] != s.prv[`SY_IN0 + i]) begin
        n.in_cnt[i] = '0;
      end else if (s.in_cnt[i] != IN_LIM) begin
        n.in_cnt[i] = s.in_cnt[i] + 24'h000001;
      end
      n.in_on[i] = sy[`SY_IN0 + i] | (s.in_cnt[i] != IN_LIM);
      fc[i] = (s.in_on[i] & ~s.cfg[i][`CFG_DIRDIS]) | s.duty[i][`DUTY_ON];
      n.fc_prev[i] = fc[i];
      n.fc_hi[i] = s.fc_hi[i] | fc[i];
      dl[i] = (fc[i] & ~s.fc_prev[i] & s.fc_hi[i]) | (retry_rst & s.retry[`RT_EN]);
      if (to_fs) begin
        n.latched[i] = 1'b0;
        n.off[i] = 1'b0;
        n.blocked[i] = 1'b0;
        n.rcnt[i] = '0;
      end else if (dl[i] && s.latched[i] && !lf[i]) begin
        n.latched[i] = 1'b0;
        n.off[i] = 1'b0;
        n.blocked[i] = 1'b0;
        n.rcnt[i] = '0;
      end else if (dl[i] && !s.latched[i] && s.off[i]) begin
        n.off[i] = 1'b0;
        n.blocked[i] = 1'b0;
      end else if (lf[i] && !s.off[i] && !s.latched[i]) begin
        n.off[i] = 1'b1;
        n.blocked[i] = 1'b1;
        n.rtim[i] = '0;
      end else if (s.off[i] && !s.latched[i] && s.retry[`RT_EN]) begin
        if (s.rtim[i] < rt_lim) begin
          n.rtim[i] = s.rtim[i] + 24'h000001;
        end else if (s.rcnt[i] == s.retry[3:0] && lf[i]) begin
          n.latched[i] = 1'b1;
        end else begin
          n.off[i] = 1'b0;
          n.blocked[i] = 1'b0;
          n.rtim[i] = '0;
          if (s.rcnt[i] != s.retry[3:0]) begin
            n.rcnt[i] = s.rcnt[i] + 4'h1;
          end
        end
      end
      // Sticky bits: set wins over the clear by a read.
      if (to_norm && !s.latched[i]) begin
        n.fault[i] = '0;
      end else if (to_fs) begin
        n.fault[i] = '0;
      end else begin
        n.fault[i] = s.fault[i] & ~(clr[i] & ~c[i] & {3'b111, {3{~s.latched[i] & ~s.blocked[i]}}});
      end
      n.fault[i] = n.fault[i] | c[i];
      // PWM module: staggered start, then an 8-bit duty counter.
      pen[i] = s.global_config_register[`GCR_PWM0 + i] & ~(clkf & ~s.ocr[i][`OCR_CLKINT]);
      tick[i] = s.ocr[i][`OCR_CLKINT] ? int_tick : ext_rise & (~s.ocr[i][`OCR_PRESC] | s.ext_half);
      if (!pen[i]) begin
        n.running[i] = 1'b0;
        n.dly[i] = '0;
      end else if (tick[i] && !s.running[i]) begin
        if (s.dly[i] == {s.cfg[i][2:0], `DLY_SHIFT}) begin
          n.running[i] = 1'b1;
          n.pcnt[i] = '0;
        end else begin
          n.dly[i] = s.dly[i] + 8'h01;
        end
      end else if (tick[i]) begin
        n.pcnt[i] = s.pcnt[i] + 8'h01;
      end
      pout[i] = s.running[i] & ((s.duty[i][7:0] == `DUTY_FULL) | (s.pcnt[i] <= s.duty[i][7:0]));
      if (s.mode != M_NORMAL) begin
        tgt[i] = sy[`SY_IN0 + i];
      end else begin
        tgt[i] = (sy[`SY_IN0 + i] & s.cfg[i][`CFG_DIRDIS]) | (s.duty[i][`DUTY_ON] & pout[i] & pen[i])
                 | (s.duty[i][`DUTY_ON] & ~pen[i]);
      end
      n.hson[i] = tgt[i] & ~n.off[i] & ~n.latched[i] & ~undervoltage_fault & ~ovf;
    end

    // Global sticky bits and the status pins.
    n.st_uv = (n.st_uv & ~st_clr[0]) | undervoltage_fault;
    n.st_ov = (n.st_ov & ~st_clr[1]) | ovf;
    n.st_clk = (n.st_clk & ~st_clr[2]) | clkf;
    n.fmode = (|lf) | (|c) | ovf | clkf;
    n.fsb_n = ~(n.fmode | (|n.latched));
    n.fs_n = (n.mode == M_NORMAL);
  end

  // State register; power-on sets the power-up flag and clears latches.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s <= '0;
      s.mode <= M_NORMAL;
      s.sy1 <= 7'h02;
      s.sy2 <= 7'h02;
      s.prv <= 7'h02;
      s.ocr <= {2{`OCR_RST}};
      s.global_config_register <= `GCR_RST;
      s.retry <= `RETRY_RST;
      s.por <= 1'b1;
      s.fs_n <= 1'b1;
      s.fsb_n <= 1'b1;
    end else begin
      s <= n;
    end
  end
endmodule
`default_nettype wire

// File: hdl/switch_host.sv
// Purpose: Host end: APB registers that drive the serial link and direct pins.
// Assumes: Software composes each 16-bit word, including the watchdog bit.
// Notes: One word in flight; a command write while busy is ignored.
`timescale 1ns/1ns
`default_nettype none
`include "ctl_cfg.svh"
module switch_host import ctl_pkg::*; #(
  parameter int SPI_DIV = `SPI_DIV_CYC
) (
  input wire logic pclk, // System clock.
  input wire logic presetn, // Asynchronous reset, active low.
  input wire logic psel, // APB select.
  input wire logic penable, // APB enable.
  input wire logic pwrite, // APB write.
  input wire logic [7:0] paddr, // APB byte address.
  input wire logic [31:0] pwdata, // APB write data.
  output logic [31:0] prdata, // APB read data.
  output logic pready, // APB ready.
  output logic pslverr, // APB error on unmapped address.
  ctl_link_if.host link // Serial link and status pins.
);
  localparam logic [7:0] DIV_LIM = 8'(SPI_DIV - 1);
  host_state_t s;
  host_state_t n;

  // Outputs come straight from the state flops.
  assign prdata = s.prdata;
  assign pready = s.pready;
  assign pslverr = s.pslverr;
  assign link.sclk = s.sclk;
  assign link.cs_n = s.cs_n;
  assign link.mosi = s.mosi;
  assign link.reset_pin_n = s.pins[0];
  assign link.dir_in = s.pins[2:1];

  // APB slave and serial word engine.
  always_comb begin
    logic tick;
    n = s;
    n.sy1 = {link.failsafe_out_n, link.fault_status_n, link.miso};
    n.sy2 = s.sy1;
    n.pready = 1'b0;
    n.pslverr = 1'b0;
    tick = (s.div == DIV_LIM);
    n.div = tick ? 8'h00 : s.div + 8'h01;
    if (psel && !penable) begin
      n.pready = 1'b1;
      case (paddr)
        `H_CMD: n.prdata = {16'h0000, s.tx};
        `H_RX: n.prdata = {16'h0000, s.rxw};
        `H_PINS: n.prdata = {29'h00000000, s.pins};
        `H_STAT: n.prdata = {29'h00000000, s.sy2[2], s.sy2[1], s.phase != H_IDLE};
        default: begin
          n.prdata = 32'h00000000;
          n.pslverr = 1'b1;
        end
      endcase
    end
    if (psel && penable && s.pready && pwrite) begin
      if (paddr == `H_CMD && s.phase == H_IDLE) begin
        n.tx = pwdata[15:0];
        n.mosi = pwdata[15];
        n.cs_n = 1'b0;
        n.edges = '0;
        n.div = '0;
        n.phase = H_SHIFT;
      end else if (paddr == `H_PINS) begin
        n.pins = pwdata[2:0];
      end
    end
    case (s.phase)
      H_IDLE: begin
        n.cs_n = n.cs_n;
      end
      H_SHIFT: begin
        if (tick && s.edges == `HOST_EDGES) begin
          n.cs_n = 1'b1;
          n.phase = H_GAP;
        end else if (tick) begin
          n.sclk = ~s.sclk;
          n.edges = s.edges + 6'h01;
          if (!s.sclk) begin
            n.rx = {s.rx[14:0], s.sy2[0]};
          end else begin
            n.tx = {s.tx[14:0], 1'b0};
            n.mosi = s.tx[14];
          end
        end
      end
      H_GAP: begin
        if (tick) begin
          n.rxw = s.rx;
          n.phase = H_IDLE;
        end
      end
      default: begin
        n.phase = H_IDLE;
      end
    endcase
  end

  // State register.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s <= '0;
      s.phase <= H_IDLE;
      s.cs_n <= 1'b1;
      s.sy1 <= 3'h7;
      s.sy2 <= 3'h7;
    end else begin
      s <= n;
    end
  end
endmodule
`default_nettype wire

// File: verification/switch_assertions.sv
// Purpose: Concurrent checks on the link between host and switch device, and on the device fault reactions.
// Assumes: One pclk domain and a serial divide of 8 in the host.
// Notes: Instantiated beside the link interface in tb_top.
`timescale 1ns/1ns
`default_nettype none
module switch_assertions (
  input wire logic pclk, // Clock.
  input wire logic presetn, // Reset, active low.
  input wire logic sclk, // Serial clock.
  input wire logic cs_n, // Frame select, active low.
  input wire logic mosi, // Serial data to device.
  input wire logic fault_status_n, // Fault pin, active low.
  input wire logic [1:0] hson, // Channel on commands.
  input wire logic fault_mode, // Fault mode flag.
  input wire logic [1:0] overcurrent_fault, // Overcurrent causes.
  input wire logic overvoltage // Supply overvoltage.
);
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  logic sclk_reg;
  logic [4:0] rises_reg;
  // Counts serial clock rises inside one frame.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sclk_reg <= 1'b0;
      rises_reg <= 5'h00;
    end else begin
      sclk_reg <= sclk;
      rises_reg <= cs_n ? 5'h00 : rises_reg + {4'h0, sclk & ~sclk_reg};
    end
  end
  // Each word is whole, and the serial clock is quiet and slow enough.
  a_frame_bits: assert property ($rose(cs_n) |-> rises_reg == 5'h10) else $error("frame without 16 rises");
  a_sclk_idle: assert property (cs_n |-> !sclk) else $error("serial clock runs outside a frame");
  a_sclk_half: assert property ($rose(sclk) |-> sclk [*4] ##[1:8] !sclk) else $error("serial clock high too short");
  a_mosi_hold: assert property (sclk && $past(sclk) |-> $stable(mosi)) else $error("data moved while clock high");
  // Fault reactions of the device.
  a_oc_pin: assert property (overcurrent_fault[0] [*6] |-> !fault_status_n) else $error("fault pin high");
  a_oc_off: assert property ($rose(overcurrent_fault[0]) |-> ##[1:6] !hson[0]) else $error("channel kept on");
  a_ov_both: assert property (overvoltage [*6] |-> hson == 2'b00) else $error("a channel kept on");
  a_ov_mode: assert property (overvoltage [*6] |-> fault_mode) else $error("fault mode not entered");
endmodule
`default_nettype wire

// File: verification/tb_top.sv
// Purpose: Drives the host over APB and the device fault inputs.
// Assumes: Shortened watchdog, idle and retry counts.
// Notes: Random duty and disabled-fault values from a fixed seed.
`timescale 1ns/1ns
`default_nettype none
module tb_top;
  logic pclk = 1'b0;
  logic presetn, psel, penable, pwrite, pready, pslverr, e, wd, ov, uv, ext_clk, fmode, vdd, cf;
  logic [7:0] paddr, d;
  logic [31:0] pwdata, prdata, r;
  logic [2:0][1:0] lat, dis;
  logic [1:0] hson;
  integer seed = 32'hb7d8f045;
  int compares, miscompares, k, ons;
  ctl_link_if link();
  switch_host switch_host_inst (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .link(link));
  switch_ctl #(.WD_CYC(3000), .IN_CYC(1500), .RETRY_BASE(100)) switch_ctl_inst (.pclk(pclk), .presetn(presetn),
    .link(link), .vdd_ok(vdd), .ext_clk_pin(ext_clk), .overcurrent_fault(lat[0]), .short_circuit_fault(lat[1]),
    .overtemp_fault(lat[2]), .short_to_supply(dis[0]), .open_load_on(dis[1]), .open_load_off(dis[2]),
    .undervoltage_fault(uv), .overvoltage(ov), .ext_clock_fail(cf), .hson(hson), .fault_mode(fmode));
  switch_assertions switch_assertions_inst (.pclk(pclk), .presetn(presetn), .sclk(link.sclk), .cs_n(link.cs_n),
    .mosi(link.mosi), .fault_status_n(link.fault_status_n), .hson(hson), .fault_mode(fmode),
    .overcurrent_fault(lat[0]), .overvoltage(ov));
  // Clocks for the bus and the external PWM pin.
  always #10 pclk = ~pclk;
  always @(posedge pclk) ext_clk <= ~ext_clk;
  // Builds a serial word: toggle bit, address, read flag, data.
  function automatic logic [15:0] mkw(input logic w, input logic [2:0] a, input logic rd, input logic [10:0] v);
    return {w, a, rd, v};
  endfunction
  task automatic chk(input string n, input logic [31:0] s, input logic [31:0] x);
    compares++;
    if (s !== x) begin
      miscompares++;
      $display("[ERR] %s expected %h seen %h", n, x, s);
    end
  endtask
  // One APB transfer; waits for pready at a rising edge.
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] v);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= v;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    r = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  // Sends one word with a toggled watchdog bit and waits until it is done.
  task automatic send(input logic [2:0] a, input logic rd, input logic [10:0] v);
    wd = ~wd;
    apb(1'b1, 8'h00, {16'h0000, mkw(wd, a, rd, v)});
    do apb(1'b0, 8'h0C, 32'h00000000); while (r[0] !== 1'b0);
    repeat (5) @(posedge pclk);
  endtask
  task automatic results;
    $display("compares %0d miscompares %0d", compares, miscompares);
    if (miscompares == 0 && compares > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask
  // Cuts a hang short.
  initial begin
    repeat (30000) @(posedge pclk);
    miscompares++;
    results;
  end
  // Main sequence.
  initial begin
    {presetn, psel, penable, pwrite, wd, ov, uv, ext_clk, vdd, cf} = 10'h000;
    {paddr, pwdata, lat, dis} = '0;
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    apb(1'b0, 8'h0C, 32'h00000000);
    chk("stat", r[2:0], 3'h6);
    apb(1'b0, 8'h10, 32'h00000000);
    chk("slverr", {31'h0, e}, 32'h00000001);
    chk("slvdata", r, 32'h00000000);
    // Reset pin rise without logic supply must not arm the watchdog.
    apb(1'b1, 8'h08, 32'h00000001);
    repeat (3100) @(posedge pclk);
    chk("failsafe_out_n", link.failsafe_out_n, 1'b1);
    vdd <= 1'b1;
    apb(1'b1, 8'h08, 32'h00000000);
    apb(1'b1, 8'h08, 32'h00000001);
    send(3'h0, 1'b0, 11'h1FF);
    chk("hson", hson, 2'h1);
    d = 8'($random(seed));
    send(3'h1, 1'b0, {3'h1, d});
    chk("hson", hson, 2'h3);
    // Half duty on the internal clock: 128 of 256 steps of 16 cycles each.
    send(3'h0, 1'b0, 11'h17F);
    send(3'h6, 1'b0, 11'h0B8);
    repeat (32) @(posedge pclk);
    for (k = 0; k < 4096; k++) begin
      @(posedge pclk);
      ons += hson[0];
    end
    chk("duty", ons, 32'h00000800);
    send(3'h6, 1'b0, 11'h028);
    send(3'h0, 1'b0, 11'h1FF);
    for (k = 0; k < 3; k++) begin
      lat[k] <= 2'h1;
      repeat (20) @(posedge pclk);
      chk("fsb", link.fault_status_n, 1'b0);
      chk("hson0", hson[0], 1'b0);
      chk("fmode", fmode, 1'b1);
      lat <= '0;
      repeat (300) @(posedge pclk);
      chk("fsb", link.fault_status_n, 1'b1);
      chk("hson0", hson[0], 1'b1);
    end
    for (k = 0; k < 3; k++) begin
      send(3'h0, 1'b1, 11'h100);
      apb(1'b0, 8'h04, 32'h00000000);
      if (k == 1) chk("fault0", r[5:0], 6'h07);
      if (k == 2) chk("fault0", r[5:0], 6'h00);
    end
    dis <= 6'($random(seed));
    repeat (20) @(posedge pclk);
    chk("fmode", fmode, 1'b0);
    dis <= '0;
    for (k = 0; k < 3; k++) begin
      {cf, uv, ov} <= 3'h1 << k;
      repeat (20) @(posedge pclk);
      chk("hson", hson, (k == 2) ? 2'h3 : 2'h0);
      chk("fmode", fmode, 1'b1);
      {cf, uv, ov} <= 3'h0;
      repeat (300) @(posedge pclk);
    end
    repeat (3200) @(posedge pclk);
    chk("failsafe_out_n", link.failsafe_out_n, 1'b0);
    apb(1'b1, 8'h08, 32'h00000005);
    repeat (10) @(posedge pclk);
    chk("hson", hson, 2'h2);
    wd = 1'b0;
    send(3'h0, 1'b0, 11'h000);
    send(3'h0, 1'b0, 11'h000);
    chk("failsafe_out_n", link.failsafe_out_n, 1'b1);
    chk("hson", hson, 2'h0);
    results;
  end
endmodule
`default_nettype wire
